// File: rtl/ocs_pkg.sv
package ocs_pkg;
	localparam int OCS_DATA_W = 24;
	localparam int OCS_CH_W = 4;
	localparam int OCS_CNT_W = 16;
	localparam int OCS_EXC_HOLD = 64;
	localparam int OCS_GUARD_W = 2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SELECT = 3'h1,
		ST_SETTLE = 3'h3,
		ST_CONVERT = 3'h2,
		ST_WAIT = 3'h6,
		ST_COMBINE = 3'h7,
		ST_DONE = 3'h5,
		ST_BGWRITE = 3'h4
	} ocs_state_t;

	localparam logic [2:0] MODE_SE_VOLT = 3'h0;
	localparam logic [2:0] MODE_SE_TC = 3'h1;
	localparam logic [2:0] MODE_DIFF = 3'h2;
	localparam logic [2:0] MODE_SE_RATIO = 3'h3;
	localparam logic [2:0] MODE_DIFF_RATIO = 3'h4;

	localparam logic [1:0] PH_ONE = 2'h0;
	localparam logic [1:0] PH_TWO = 2'h1;
	localparam logic [1:0] PH_FOUR = 2'h3;
	localparam int SHIFT_TWO = 1;
	localparam int SHIFT_FOUR = 2;

	function automatic logic ocs_is_diff(input logic [2:0] m);
		return (m == MODE_DIFF) || (m == MODE_DIFF_RATIO);
	endfunction : ocs_is_diff

	function automatic logic ocs_is_ratio(input logic [2:0] m);
		return (m == MODE_SE_RATIO) || (m == MODE_DIFF_RATIO);
	endfunction : ocs_is_ratio

	function automatic logic ocs_is_se_direct(input logic [2:0] m);
		return (m == MODE_SE_VOLT) || (m == MODE_SE_TC);
	endfunction : ocs_is_se_direct
endpackage : ocs_pkg

// File: rtl/ocs_mem_if.sv
interface ocs_mem_if #(parameter int DATA_W = 24, parameter int CH_W = 4);
	logic we;
	logic [CH_W-1:0] waddr;
	logic signed [DATA_W-1:0] wdata;
	logic [CH_W-1:0] raddr;
	logic signed [DATA_W-1:0] rdata;

	modport user (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ocs_mem_if

// File: rtl/ocs_offset_mem.sv
module ocs_offset_mem #(
	parameter int DATA_W = 24,
	parameter int CH_W = 4
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	ocs_mem_if.mem port
);
	// Offsets live in plain storage; only the read port is registered, so no reset on the array.
	logic signed [DATA_W-1:0] store [2**CH_W];
	logic signed [DATA_W-1:0] rdata_r;

	always_ff @(posedge core_clk_i) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_r <= '0;
		end else if (port.we && (port.waddr == port.raddr)) begin
			rdata_r <= port.wdata;
		end else begin
			rdata_r <= store[port.raddr];
		end
	end

	assign port.rdata = rdata_r;
endmodule : ocs_offset_mem

// File: rtl/ocs_sequencer.sv
// Overview of operation
// - Input reversal: normal then swapped, subtract.
// - Excitation reversal: subtract opposite results, halve.
// - Both: select, then four polarity phases.
// - Same settling delay before every sub-measurement.
// - Each excitation polarity held identical time.
// - Single-ended ratiometric uses self-calibration offset.
// - No reversal: subtract grounded-amplifier offset.
// - Differential offset taken during background calibration.
// - Single-ended volt/TC offset-at-start measures grounded offset first.
// - Offset-at-start clear: use stored calibration offset.
// - Disabled options still get stored offset correction.
module ocs_sequencer import ocs_pkg::*; #(
	parameter int DATA_W = OCS_DATA_W,
	parameter int CH_W = OCS_CH_W,
	parameter int CNT_W = OCS_CNT_W,
	parameter int EXC_HOLD_CYCLES = OCS_EXC_HOLD
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic start_i,
	input wire logic [2:0] mode_i,
	input wire logic [CH_W-1:0] channel_i,
	input wire logic input_reversal_enable_i,
	input wire logic excitation_reversal_enable_i,
	input wire logic offset_at_start_enable_i,
	input wire logic [CNT_W-1:0] settle_cycles_i,
	input wire logic bgcal_start_i,
	input wire logic [CH_W-1:0] bgcal_channel_i,
	input wire logic adc_done_i,
	input wire logic signed [DATA_W-1:0] adc_data_i,
	output logic adc_start_o,
	output logic terminal_select_o,
	output logic [CH_W-1:0] terminal_channel_o,
	output logic input_swap_o,
	output logic excitation_on_o,
	output logic excitation_negative_o,
	output logic amp_ground_o,
	output logic busy_o,
	output logic done_o,
	output logic signed [DATA_W-1:0] result_o
);
	localparam int AW = DATA_W + OCS_GUARD_W;
	typedef logic signed [AW-1:0] ocs_acc_t;

	if (DATA_W < 8 || CH_W < 1 || CNT_W < 2 || EXC_HOLD_CYCLES < 1 || EXC_HOLD_CYCLES >= 2**CNT_W) begin : g_bad_cfg
		$error("ocs_sequencer: unsupported parameter values");
	end

	localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(EXC_HOLD_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;

	typedef struct packed {
		ocs_state_t st;
		logic [2:0] mode;
		logic [CH_W-1:0] chan;
		logic rev_in;
		logic rev_ex;
		logic [1:0] last;
		logic [1:0] phase;
		logic ofs_phase;
		logic bg;
		logic use_mem;
		logic got;
		logic [CNT_W-1:0] settle;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] hold;
		ocs_acc_t acc;
		logic signed [DATA_W-1:0] ofs;
		logic adc_start;
		logic sel;
		logic swap;
		logic exc_on;
		logic exc_neg;
		logic gnd;
		logic busy;
		logic done;
		logic signed [DATA_W-1:0] result;
	} ocs_state_s_t;

	ocs_state_s_t s_r;
	ocs_state_s_t s_nxt;
	ocs_mem_if #(.DATA_W(DATA_W), .CH_W(CH_W)) mif ();

	ocs_offset_mem #(.DATA_W(DATA_W), .CH_W(CH_W)) u_offset_mem (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.port(mif.mem)
	);

	assign mif.we = (s_r.st == ST_BGWRITE);
	assign mif.waddr = s_r.chan;
	assign mif.wdata = s_r.ofs;
	assign mif.raddr = s_r.chan;

	always_comb begin
		ocs_acc_t sample;
		ocs_acc_t offs;
		logic neg;
		s_nxt = s_r;
		sample = ocs_acc_t'(adc_data_i);
		offs = s_r.use_mem ? ocs_acc_t'(mif.rdata) : ocs_acc_t'(s_r.ofs);
		neg = s_r.exc_neg ^ s_r.swap;
		s_nxt.adc_start = 1'b0;
		s_nxt.done = 1'b0;
		case (s_r.st)
			ST_IDLE: begin
				s_nxt.busy = 1'b0;
				if (start_i) begin
					s_nxt.busy = 1'b1;
					s_nxt.mode = mode_i;
					s_nxt.chan = channel_i;
					s_nxt.settle = settle_cycles_i;
					s_nxt.rev_in = input_reversal_enable_i && ocs_is_diff(mode_i);
					s_nxt.rev_ex = excitation_reversal_enable_i && ocs_is_ratio(mode_i);
					if (s_nxt.rev_in && s_nxt.rev_ex) begin
						s_nxt.last = PH_FOUR;
					end else if (s_nxt.rev_in || s_nxt.rev_ex) begin
						s_nxt.last = PH_TWO;
					end else begin
						s_nxt.last = PH_ONE;
					end
					// An offset measured right now beats a stale calibration value.
					s_nxt.ofs_phase = offset_at_start_enable_i && ocs_is_se_direct(mode_i);
					s_nxt.use_mem = !s_nxt.ofs_phase;
					s_nxt.bg = 1'b0;
					s_nxt.phase = 2'h0;
					s_nxt.acc = '0;
					s_nxt.st = ST_SELECT;
				end else if (bgcal_start_i) begin
					// Differential offsets are refreshed here, never inside a measurement.
					s_nxt.busy = 1'b1;
					s_nxt.chan = bgcal_channel_i;
					s_nxt.settle = settle_cycles_i;
					s_nxt.bg = 1'b1;
					s_nxt.ofs_phase = 1'b1;
					s_nxt.rev_in = 1'b0;
					s_nxt.rev_ex = 1'b0;
					s_nxt.mode = MODE_DIFF;
					s_nxt.phase = 2'h0;
					s_nxt.acc = '0;
					s_nxt.st = ST_SELECT;
				end
			end
			ST_SELECT: begin
				s_nxt.sel = 1'b1;
				s_nxt.gnd = s_r.ofs_phase;
				s_nxt.swap = 1'b0;
				s_nxt.exc_neg = 1'b0;
				s_nxt.exc_on = !s_r.ofs_phase && ocs_is_ratio(s_r.mode);
				s_nxt.cnt = s_r.settle;
				s_nxt.st = ST_SETTLE;
			end
			ST_SETTLE: begin
				// Every phase waits the same programmed interval.
				if (s_r.cnt == CNT_ZERO) begin
					s_nxt.adc_start = 1'b1;
					s_nxt.st = ST_CONVERT;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			ST_CONVERT: begin
				s_nxt.hold = HOLD_LOAD;
				s_nxt.got = 1'b0;
				s_nxt.st = ST_WAIT;
			end
			ST_WAIT: begin
				// Excitation drops at a fixed count, not at conversion end, so both polarities match.
				if (s_r.hold != CNT_ZERO) begin
					s_nxt.hold = s_r.hold - 1'b1;
				end else begin
					s_nxt.exc_on = 1'b0;
				end
				if (adc_done_i && !s_r.got) begin
					s_nxt.got = 1'b1;
					if (s_r.ofs_phase) begin
						s_nxt.ofs = adc_data_i;
					end else if (neg) begin
						s_nxt.acc = ocs_acc_t'(s_r.acc - sample);
					end else begin
						s_nxt.acc = ocs_acc_t'(s_r.acc + sample);
					end
				end
				if ((s_r.got || adc_done_i) && (s_r.hold == CNT_ZERO || !s_r.exc_on)) begin
					s_nxt.cnt = s_r.settle;
					s_nxt.exc_on = ocs_is_ratio(s_r.mode) && !s_r.bg;
					if (s_r.bg) begin
						s_nxt.gnd = 1'b0;
						s_nxt.exc_on = 1'b0;
						s_nxt.st = ST_BGWRITE;
					end else if (s_r.ofs_phase) begin
						s_nxt.ofs_phase = 1'b0;
						s_nxt.gnd = 1'b0;
						s_nxt.st = ST_SETTLE;
					end else if (s_r.phase == s_r.last) begin
						s_nxt.exc_on = 1'b0;
						s_nxt.st = ST_COMBINE;
					end else begin
						s_nxt.phase = s_r.phase + 2'h1;
						// Excitation flips every phase; inputs flip after it or alone.
						if (s_r.rev_ex) begin
							s_nxt.exc_neg = !s_r.exc_neg;
							s_nxt.swap = s_r.rev_in ? s_nxt.phase[1] : 1'b0;
						end else begin
							s_nxt.swap = !s_r.swap;
						end
						s_nxt.st = ST_SETTLE;
					end
				end
			end
			ST_COMBINE: begin
				s_nxt.sel = 1'b0;
				s_nxt.swap = 1'b0;
				s_nxt.exc_neg = 1'b0;
				case (s_r.last)
					PH_ONE: s_nxt.result = DATA_W'(ocs_acc_t'(s_r.acc - offs));
					PH_TWO: s_nxt.result = DATA_W'(s_r.acc >>> SHIFT_TWO);
					default: s_nxt.result = DATA_W'(s_r.acc >>> SHIFT_FOUR);
				endcase
				s_nxt.done = 1'b1;
				s_nxt.st = ST_DONE;
			end
			ST_DONE: begin
				s_nxt.busy = 1'b0;
				s_nxt.st = ST_IDLE;
			end
			ST_BGWRITE: begin
				s_nxt.sel = 1'b0;
				s_nxt.bg = 1'b0;
				s_nxt.busy = 1'b0;
				s_nxt.st = ST_IDLE;
			end
			default: begin
				s_nxt = '0;
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign adc_start_o = s_r.adc_start;
	assign terminal_select_o = s_r.sel;
	assign terminal_channel_o = s_r.chan;
	assign input_swap_o = s_r.swap;
	assign excitation_on_o = s_r.exc_on;
	assign excitation_negative_o = s_r.exc_neg;
	assign amp_ground_o = s_r.gnd;
	assign busy_o = s_r.busy;
	assign done_o = s_r.done;
	assign result_o = s_r.result;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	logic [CNT_W-1:0] settle_seen_r;
	logic [CNT_W-1:0] exc_len_r;
	logic [CNT_W-1:0] exc_first_r;
	logic [2:0] starts_r;
	logic exc_seg_end;
	// A polarity ends when excitation drops or flips, so both cases close the same count.
	assign exc_seg_end = s_r.exc_on && (!s_nxt.exc_on || (s_nxt.exc_neg != s_r.exc_neg));
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			settle_seen_r <= '0;
			exc_len_r <= '0;
			exc_first_r <= '0;
			starts_r <= '0;
		end else begin
			settle_seen_r <= (s_r.st == ST_SETTLE) ? settle_seen_r + 1'b1 : '0;
			exc_len_r <= (s_r.exc_on && !exc_seg_end) ? exc_len_r + 1'b1 : '0;
			if (s_r.st == ST_IDLE) begin
				exc_first_r <= '0;
				starts_r <= '0;
			end else begin
				if (exc_seg_end && exc_first_r == '0) begin
					exc_first_r <= exc_len_r;
				end
				if (s_r.adc_start) begin
					starts_r <= starts_r + 3'h1;
				end
			end
		end
	end

	a_settle_len: assert property ((s_r.st == ST_SETTLE) && (s_nxt.st == ST_CONVERT) |-> settle_seen_r == s_r.settle)
		else $error("settle interval differs from programmed value");
	a_exc_equal: assert property (exc_seg_end && s_r.rev_ex && exc_first_r != '0
		|-> exc_len_r == exc_first_r)
		else $error("excitation polarities held unequal times");
	a_done_pulse: assert property (done_o |=> !done_o)
		else $error("completion lasted more than one cycle");
	a_done_count: assert property (done_o |-> starts_r == 3'(s_r.last) + 3'h1 + 3'(!s_r.use_mem))
		else $error("wrong number of sub-measurements before completion");
	a_swap_second: assert property ($rose(input_swap_o) |-> s_r.rev_in && s_r.phase == (s_r.rev_ex ? 2'h2 : 2'h1))
		else $error("inputs swapped in wrong phase");
	a_exc_flip: assert property ($rose(excitation_negative_o) |-> s_r.rev_ex && s_r.phase[0])
		else $error("excitation reversed without reversal enabled");
	a_ground_first: assert property ($rose(amp_ground_o) |-> (s_r.ofs_phase && s_r.phase == 2'h0))
		else $error("grounded offset not taken before inputs");
	a_bg_write: assert property ((s_r.st == ST_WAIT) && s_r.bg && s_nxt.st != ST_WAIT |=> mif.we ##1 !busy_o)
		else $error("background offset not stored");
	a_mem_offset: assert property ((s_r.st == ST_COMBINE) && s_r.last == PH_ONE && s_r.use_mem
		|=> result_o == DATA_W'(ocs_acc_t'($past(s_r.acc) - ocs_acc_t'($past(mif.rdata)))))
		else $error("stored offset not subtracted");
	a_four_avg: assert property ((s_r.st == ST_COMBINE) && s_r.last == PH_FOUR
		|=> result_o == DATA_W'($past(s_r.acc) >>> SHIFT_FOUR))
		else $error("four-phase result not averaged");

	c_four_phase: cover property (done_o && s_r.last == PH_FOUR);
	c_offset_start: cover property (done_o && !s_r.use_mem);
	c_bgcal: cover property (mif.we);
	c_two_phase: cover property (done_o && s_r.last == PH_TWO);
endmodule : ocs_sequencer

// File: testbench/ocs_sensor_model.sv
module ocs_sensor_model import ocs_pkg::*; (
	input wire logic core_clk_i,
	input wire logic adc_start_i,
	input wire logic swap_i,
	input wire logic neg_i,
	input wire logic ground_i,
	input wire logic [3:0] lat_i,
	input wire logic signed [OCS_DATA_W-1:0] signal_i,
	input wire logic signed [OCS_DATA_W-1:0] offset_i,
	output logic adc_done_o,
	output logic signed [OCS_DATA_W-1:0] adc_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt = 4'h0;
	logic signed [OCS_DATA_W-1:0] val = 24'sh000000;
	initial adc_done_o = 1'b0;
	initial adc_data_o = 24'sh5A5A5A;
	// Data toggles outside the done cycle so a late sample never looks valid.
	always @(posedge core_clk_i) begin
		adc_done_o <= 1'b0;
		adc_data_o <= ~adc_data_o;
		if (adc_start_i) begin
			cnt <= lat_i;
			if (ground_i)
				val <= offset_i;
			else if (neg_i ^ swap_i)
				val <= offset_i - signal_i;
			else
				val <= offset_i + signal_i;
		end else if (cnt == 4'h1) begin
			adc_done_o <= 1'b1;
			adc_data_o <= val;
			cnt <= 4'h0;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule : ocs_sensor_model

// File: testbench/ocs_sequencer_tb.sv
module ocs_sequencer_tb import ocs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic start_i = 1'b0;
	logic ir = 1'b0;
	logic er = 1'b0;
	logic oas = 1'b0;
	logic bgs = 1'b0;
	logic [2:0] mode = 3'h0;
	logic [3:0] lat = 4'h2;
	logic [3:0] chan = 4'h1;
	logic [15:0] settle = 16'h0003;
	logic signed [23:0] sig = 24'sh0012A4;
	logic signed [23:0] off = 24'sh000035;
	logic signed [23:0] o1 = 24'sh000035;
	logic signed [23:0] adc_data;
	logic signed [23:0] result;
	logic adc_done, adc_start, tsel, swap, exc_on, exc_neg, gnd, busy, done;
	logic [3:0] tch;
	logic [1:0] seqv [4];
	int n_mismatch = 0;
	int checks_done = 0;
	int n_sel_bad = 0;
	int n_adc, n_pos, n_neg, n_gnd, gap, min_gap;

	always #25 core_clk_i = ~core_clk_i;

	ocs_sequencer #(.EXC_HOLD_CYCLES(4)) u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.start_i(start_i), .mode_i(mode), .channel_i(chan), .input_reversal_enable_i(ir),
		.excitation_reversal_enable_i(er), .offset_at_start_enable_i(oas), .settle_cycles_i(settle),
		.bgcal_start_i(bgs), .bgcal_channel_i(chan), .adc_done_i(adc_done), .adc_data_i(adc_data),
		.adc_start_o(adc_start), .terminal_select_o(tsel), .terminal_channel_o(tch), .input_swap_o(swap),
		.excitation_on_o(exc_on), .excitation_negative_o(exc_neg), .amp_ground_o(gnd), .busy_o(busy),
		.done_o(done), .result_o(result));

	ocs_sensor_model u_model (.core_clk_i(core_clk_i), .adc_start_i(adc_start), .swap_i(swap),
		.neg_i(exc_neg), .ground_i(gnd), .lat_i(lat), .signal_i(sig), .offset_i(off),
		.adc_done_o(adc_done), .adc_data_o(adc_data));

	always @(posedge core_clk_i) begin
		gap <= adc_done ? 0 : gap + 1;
		if (adc_start) begin
			if (n_adc < 4)
				seqv[n_adc] <= {swap, exc_neg};
			if (gap < min_gap)
				min_gap <= gap;
			n_adc <= n_adc + 1;
			if (tsel !== 1'b1 || tch !== chan)
				n_sel_bad <= n_sel_bad + 1;
		end
		if (exc_on && exc_neg)
			n_neg <= n_neg + 1;
		if (exc_on && !exc_neg)
			n_pos <= n_pos + 1;
		if (gnd)
			n_gnd <= n_gnd + 1;
	end

	task automatic chk(input logic c, input string m);
		checks_done++;
		if (c !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk

	task automatic run(input logic [2:0] m, input logic i, input logic e, input logic o);
		n_adc = 0;
		n_pos = 0;
		n_neg = 0;
		n_gnd = 0;
		gap = 0;
		min_gap = 100000;
		@(posedge core_clk_i);
		mode <= m;
		ir <= i;
		er <= e;
		oas <= o;
		start_i <= 1'b1;
		@(posedge core_clk_i);
		start_i <= 1'b0;
		for (int k = 0; k < 2000; k++) begin
			@(posedge core_clk_i);
			#1;
			if (done === 1'b1)
				break;
		end
		chk(done === 1'b1, "no completion");
		@(posedge core_clk_i);
		#1;
		chk(done === 1'b0 && busy === 1'b0, "done not one cycle");
		chk(min_gap >= int'(settle), "settling too short");
		chk(tsel === 1'b0 && exc_on === 1'b0 && n_sel_bad == 0, "terminals not handled");
	endtask : run

	task automatic bgcal(input logic [3:0] c);
		n_gnd = 0;
		@(posedge core_clk_i);
		chan <= c;
		bgs <= 1'b1;
		@(posedge core_clk_i);
		bgs <= 1'b0;
		for (int k = 0; k < 2000; k++) begin
			@(posedge core_clk_i);
			#1;
			if (busy === 1'b0)
				break;
		end
		chk(n_gnd > 0 && busy === 1'b0 && tsel === 1'b0 && gnd === 1'b0, "calibration not grounded");
	endtask : bgcal

	// Offsets differ between calibration and measurement, so stored and fresh offsets give distinct results.
	task automatic t_single_phase();
		run(MODE_DIFF, 1'b0, 1'b0, 1'b0);
		chk(result === sig + off - o1 && n_adc == 1 && n_gnd == 0, "diff stored offset");
		chk(n_pos + n_neg == 0, "excitation outside ratio mode");
		run(MODE_SE_RATIO, 1'b0, 1'b0, 1'b0);
		chk(result === sig + off - o1 && n_pos > 0 && n_neg == 0, "ratio stored offset");
		run(MODE_SE_VOLT, 1'b1, 1'b1, 1'b0);
		chk(result === sig + off - o1 && n_adc == 1 && seqv[0] === 2'h0, "reversal not ignored");
		for (int m = 0; m < 2; m++) begin
			run(m[2:0], 1'b0, 1'b0, 1'b1);
			chk(result === sig && n_adc == 2 && n_gnd > 0, "offset at start");
			run(m[2:0], 1'b0, 1'b0, 1'b0);
			chk(result === sig + off - o1 && n_adc == 1, "stored se offset");
		end
	endtask : t_single_phase

	// A second channel gets its own stored offset and must leave the first one alone.
	task automatic t_channel();
		bgcal(4'h2);
		off = 24'sh000067;
		run(MODE_DIFF, 1'b0, 1'b0, 1'b0);
		chk(result === sig + off - 24'sh000051 && tch === 4'h2, "second channel offset");
		@(posedge core_clk_i);
		chan <= 4'h1;
		run(MODE_DIFF, 1'b0, 1'b0, 1'b0);
		chk(result === sig + off - o1 && tch === 4'h1, "first channel offset kept");
	endtask : t_channel

	task automatic t_reversals();
		run(MODE_DIFF, 1'b1, 1'b0, 1'b0);
		chk(result === sig && n_adc == 2 && seqv[0] === 2'h0 && seqv[1] === 2'h2, "input reversal");
		lat = 4'h4;
		run(MODE_SE_RATIO, 1'b0, 1'b1, 1'b0);
		chk(result === sig && n_adc == 2 && seqv[1] === 2'h1, "excitation reversal");
		chk(n_pos == n_neg && n_pos > 0, "unequal excitation");
		sig = -24'sh000F3C;
		run(MODE_DIFF_RATIO, 1'b1, 1'b1, 1'b0);
		chk(n_adc == 4 && seqv[0] === 2'h0 && seqv[1] === 2'h1, "phase order a");
		chk(seqv[2] === 2'h2 && seqv[3] === 2'h3, "phase order b");
		chk(result === sig && n_pos == n_neg, "four phase result");
	endtask : t_reversals

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	initial begin
		#1000000;
		n_mismatch++;
		complete_run();
	end

	initial begin
		repeat (12) @(posedge core_clk_i);
		reset_i <= 1'b0;
		@(posedge core_clk_i);
		#1;
		bgcal(4'h1);
		off = 24'sh000051;
		t_single_phase();
		t_reversals();
		t_channel();
		complete_run();
	end
endmodule : ocs_sequencer_tb
